// *** verilog/mdf_pkg.sv ***
// Package for the motor driver fault handler: fault codes, blink timing, limits.
// Assumes a 20 MHz core clock; every cycle count below is derived from that rate.
`default_nettype none

package mdf_pkg;

  // Core clock rate
  localparam int unsigned CLK_HZ = 20_000_000;

  // Blink timing in milliseconds, and the cycle counts derived from them
  localparam int unsigned BLINK_ON_MS = 200;
  localparam int unsigned BLINK_OFF_MS = 200;
  localparam int unsigned BLINK_GAP_MS = 1200;
  localparam int unsigned BLINK_ON_CYC = (CLK_HZ / 1000) * BLINK_ON_MS;
  localparam int unsigned BLINK_OFF_CYC = (CLK_HZ / 1000) * BLINK_OFF_MS;
  localparam int unsigned BLINK_GAP_CYC = (CLK_HZ / 1000) * BLINK_GAP_MS;

  // Overload persistence in milliseconds and in cycles
  localparam int unsigned OVLD_MS = 5000;
  localparam int unsigned OVLD_CYC = (CLK_HZ / 1000) * OVLD_MS;

  // Overspeed limit of the output table, r/min
  localparam int unsigned OVSPD_RPM = 270;

  // Blink counts of each fault kind; zero means the lamp is lit steadily
  localparam logic [3:0] BLINK_OVLD = 4'h2;
  localparam logic [3:0] BLINK_OVOLT = 4'h3;
  localparam logic [3:0] BLINK_SPDERR = 4'h4;
  localparam logic [3:0] BLINK_OVSPD = 4'h6;
  localparam logic [3:0] BLINK_NVDATA = 4'h7;
  localparam logic [3:0] BLINK_SENSOR = 4'h8;
  localparam logic [3:0] BLINK_STEADY = 4'h0;

  // Latched fault kind
  typedef enum logic [2:0] {
    MDF_F_NONE = 3'b000,
    MDF_F_OVLD = 3'b001,
    MDF_F_OVOLT = 3'b010,
    MDF_F_SPDERR = 3'b011,
    MDF_F_OVSPD = 3'b100,
    MDF_F_NVDATA = 3'b101,
    MDF_F_SENSOR = 3'b110,
    MDF_F_SYSTEM = 3'b111
  } mdf_fault_t;

  // Blink sequencer state
  typedef enum logic [1:0] {
    MDF_B_IDLE = 2'b00,
    MDF_B_ON = 2'b01,
    MDF_B_OFF = 2'b10,
    MDF_B_GAP = 2'b11
  } mdf_blink_t;

endpackage

`default_nettype wire

// *** verilog/mdf_blink.sv ***
// Lamp blink generator: groups of N pulses, pause, repeat; or steady light.
// Assumes the code is held stable by its driver while enable stays high.
`default_nettype none

module mdf_blink #(
  parameter int unsigned ON_CYC = mdf_pkg::BLINK_ON_CYC,
  parameter int unsigned OFF_CYC = mdf_pkg::BLINK_OFF_CYC,
  parameter int unsigned GAP_CYC = mdf_pkg::BLINK_GAP_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Display request
  input wire logic enable_i,
  input wire logic [3:0] count_i,
  // Lamp
  output logic lamp_o
);

  mdf_pkg::mdf_blink_t state;
  logic [31:0] timer;
  logic [3:0] done;

  // Timer sized for the longest phase; restarts on every phase change
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !enable_i) begin
      state <= mdf_pkg::MDF_B_IDLE;
      timer <= 32'h0000_0000;
      done <= 4'h0;
    end else begin
      unique case (state)
        mdf_pkg::MDF_B_IDLE: begin
          state <= mdf_pkg::MDF_B_ON;
          timer <= 32'h0000_0000;
          done <= 4'h0;
        end
        mdf_pkg::MDF_B_ON: begin
          if (timer == ON_CYC - 1) begin
            timer <= 32'h0000_0000;
            done <= done + 4'h1;
            state <= mdf_pkg::MDF_B_OFF;
          end else begin
            timer <= timer + 32'h0000_0001;
          end
        end
        mdf_pkg::MDF_B_OFF: begin
          if (timer == OFF_CYC - 1) begin
            timer <= 32'h0000_0000;
            state <= (done >= count_i) ? mdf_pkg::MDF_B_GAP : mdf_pkg::MDF_B_ON;
          end else begin
            timer <= timer + 32'h0000_0001;
          end
        end
        mdf_pkg::MDF_B_GAP: begin
          if (timer == GAP_CYC - 1) begin
            timer <= 32'h0000_0000;
            done <= 4'h0;
            state <= mdf_pkg::MDF_B_ON;
          end else begin
            timer <= timer + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // Steady code lights the lamp for as long as it is shown
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lamp_o <= 1'b0;
    end else begin
      // Lighting in the start-up state too would stretch the first pulse by a cycle
      lamp_o <= enable_i && ((count_i == mdf_pkg::BLINK_STEADY) ||
                (state == mdf_pkg::MDF_B_ON)); // [R18]
    end
  end

endmodule // mdf_blink

`default_nettype wire

// *** verilog/mdf_persist.sv ***
// Persistence timer: output rises once the input has stayed high a set time.
// Assumes the input is already synchronous; any low restarts the count.
`default_nettype none

module mdf_persist #(
  parameter int unsigned CYC = mdf_pkg::OVLD_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Condition and verdict
  input wire logic cond_i,
  output logic hit_o
);

  logic [31:0] cnt;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !cond_i) begin
      cnt <= 32'h0000_0000;
      hit_o <= 1'b0;
    end else if (cnt >= CYC - 1) begin
      hit_o <= 1'b1;
    end else begin
      cnt <= cnt + 32'h0000_0001;
    end
  end

endmodule // mdf_persist

`default_nettype wire

// *** verilog/mdf_fault_handler.sv ***
// Fault latch, alarm output, lamp code and step command gating of the driver.
// Assumes detector inputs are synchronous levels from analog and speed logic;
// power-up is modelled by rst_i.
`default_nettype none

// Function
// R1 - On any fault: start blink code, drop alarm output, cut motor current.
// R2 - Alarm output stays ON normally and goes OFF only while a fault is latched.
// R3 - Overload persisting five seconds raises fault with 2 blinks.
// R4 - Overvoltage raises fault with 3 blinks.
// R5 - Failure to follow command pulses raises fault with 4 blinks.
// R6 - Output table speed above 270 r/min raises fault with 6 blinks.
// R7 - Corrupt stored motor parameter raises fault with 7 blinks.
// R8 - Power-up without motor cable raises fault with 8 blinks.
// R9 - System failure lights lamp steadily instead of blinking.
// R10 - One clear pulse releases a clearable fault; alarm output returns ON.
// R11 - Power-up starts with no fault latched.
// R12 - Clear is ignored for stored-data and system faults.
// R13 - Two-pulse mode: both direction inputs active means no motion.
// R14 - Single-pulse mode: step input moves, rotation sense ON clockwise.
// R15 - Current-off input keeps motor unexcited; release re-excites.
// R16 - Clockwise command turns output table counterclockwise and vice versa.
// R17 - Resolution multiplier dropped in motion may miss angle ticks.
// R18 - Blinks 0.2 s on, 0.2 s off, group repeated after 1.2 s gap.
// R19 - Host waits 0.1 s after alarm returns ON before commanding pulses.
// R20 - First fault is latched and shown until a valid clear.
// R21 - Clear acts on its assertion edge only.
module mdf_fault_handler #(
  parameter int unsigned BLINK_ON_CYC = mdf_pkg::BLINK_ON_CYC,
  parameter int unsigned BLINK_OFF_CYC = mdf_pkg::BLINK_OFF_CYC,
  parameter int unsigned BLINK_GAP_CYC = mdf_pkg::BLINK_GAP_CYC,
  parameter int unsigned OVLD_CYC = mdf_pkg::OVLD_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Fault detectors
  input wire logic over_torque_i,
  input wire logic over_voltage_i,
  input wire logic follow_error_i,
  input wire logic over_speed_i,
  input wire logic nv_corrupt_i,
  input wire logic cable_absent_i,
  input wire logic system_fail_i,
  // Host control inputs
  input wire logic fault_clear_input_i,
  input wire logic current_off_i,
  input wire logic two_pulse_mode_i,
  input wire logic clockwise_cmd_input_i,
  input wire logic counterclockwise_cmd_input_i,
  input wire logic step_pulse_input_i,
  input wire logic rotation_sense_i,
  // Angle tick path
  input wire logic angle_tick_raw_i,
  // Outputs
  output logic fault_ok_o,
  output logic motor_enable_o,
  output logic alarm_lamp_o,
  output logic [2:0] fault_code_o,
  output logic step_o,
  output logic table_ccw_o,
  output logic angle_tick_output_o
);

  mdf_pkg::mdf_fault_t fault;
  mdf_pkg::mdf_fault_t next_fault;
  logic ovld_hit;
  logic clr_d;
  logic clr_edge;
  logic post_rst;
  logic clearable;
  logic [3:0] blink_count;

  mdf_persist #(
    .CYC(OVLD_CYC)
  ) u_ovld (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .cond_i(over_torque_i),
    .hit_o(ovld_hit)
  ); // [R3]

  // Edge of the clear input; a held clear does not wipe a later fault
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      clr_d <= 1'b0;
    end else begin
      clr_d <= fault_clear_input_i;
    end
  end
  assign clr_edge = fault_clear_input_i && !clr_d; // [R21]

  // First cycle after power-up: the only moment a missing cable is checked
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      post_rst <= 1'b1;
    end else begin
      post_rst <= 1'b0;
    end
  end

  assign clearable = (fault != mdf_pkg::MDF_F_NVDATA) &&
                     (fault != mdf_pkg::MDF_F_SYSTEM); // [R12]

  // Detector priority: the unclearable ones first, then the power-up cable check, then by blink count
  always_comb begin
    next_fault = mdf_pkg::MDF_F_NONE;
    if (system_fail_i) begin
      next_fault = mdf_pkg::MDF_F_SYSTEM; // [R9]
    end else if (nv_corrupt_i) begin
      next_fault = mdf_pkg::MDF_F_NVDATA; // [R7]
    end else if (post_rst && cable_absent_i) begin
      next_fault = mdf_pkg::MDF_F_SENSOR; // [R8]
    end else if (ovld_hit) begin
      next_fault = mdf_pkg::MDF_F_OVLD; // [R3]
    end else if (over_voltage_i) begin
      next_fault = mdf_pkg::MDF_F_OVOLT; // [R4]
    end else if (follow_error_i) begin
      next_fault = mdf_pkg::MDF_F_SPDERR; // [R5]
    end else if (over_speed_i) begin
      next_fault = mdf_pkg::MDF_F_OVSPD; // [R6]
    end
  end

  // A new fault in the clear cycle wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fault <= mdf_pkg::MDF_F_NONE; // [R11]
    end else if (fault == mdf_pkg::MDF_F_NONE) begin
      fault <= next_fault; // [R20]
    end else if (clr_edge && clearable) begin
      fault <= next_fault; // [R10]
    end
  end

  assign fault_ok_o = (fault == mdf_pkg::MDF_F_NONE); // [R2] [R1]
  assign motor_enable_o = (fault == mdf_pkg::MDF_F_NONE) && !current_off_i; // [R1] [R15]
  assign fault_code_o = fault;

  always_comb begin
    unique case (fault)
      mdf_pkg::MDF_F_OVLD: blink_count = mdf_pkg::BLINK_OVLD;
      mdf_pkg::MDF_F_OVOLT: blink_count = mdf_pkg::BLINK_OVOLT;
      mdf_pkg::MDF_F_SPDERR: blink_count = mdf_pkg::BLINK_SPDERR;
      mdf_pkg::MDF_F_OVSPD: blink_count = mdf_pkg::BLINK_OVSPD;
      mdf_pkg::MDF_F_NVDATA: blink_count = mdf_pkg::BLINK_NVDATA;
      mdf_pkg::MDF_F_SENSOR: blink_count = mdf_pkg::BLINK_SENSOR;
      mdf_pkg::MDF_F_SYSTEM: blink_count = mdf_pkg::BLINK_STEADY; // [R9]
      mdf_pkg::MDF_F_NONE: blink_count = mdf_pkg::BLINK_STEADY;
    endcase
  end

  mdf_blink #(
    .ON_CYC(BLINK_ON_CYC),
    .OFF_CYC(BLINK_OFF_CYC),
    .GAP_CYC(BLINK_GAP_CYC)
  ) u_blink (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .enable_i(fault != mdf_pkg::MDF_F_NONE),
    .count_i(blink_count),
    .lamp_o(alarm_lamp_o)
  ); // [R18] [R1]

  // Step command decode; the host's 0.1 s wait after clear is not policed
  logic cmd_step;
  logic cmd_ccw;
  always_comb begin
    if (two_pulse_mode_i) begin
      cmd_step = clockwise_cmd_input_i ^ counterclockwise_cmd_input_i; // [R13]
      cmd_ccw = clockwise_cmd_input_i; // [R16]
    end else begin
      cmd_step = step_pulse_input_i; // [R14]
      cmd_ccw = rotation_sense_i; // [R14] [R16]
    end
  end

  // Steps are registered and suppressed while the motor is not excited
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      step_o <= 1'b0;
      table_ccw_o <= 1'b0;
    end else begin
      step_o <= cmd_step && motor_enable_o; // [R1] [R15]
      table_ccw_o <= cmd_ccw;
    end
  end

  // Angle tick is passed through; a multiplier change in motion may drop one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      angle_tick_output_o <= 1'b0;
    end else begin
      angle_tick_output_o <= angle_tick_raw_i; // [R17]
    end
  end

  // Assertions
  latch_first_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fault != mdf_pkg::MDF_F_NONE && !clr_edge) |=> $stable(fault))
    else $error("latched fault changed without clear"); // [R20]
  alarm_drop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fault == mdf_pkg::MDF_F_NONE && next_fault != mdf_pkg::MDF_F_NONE)
      |=> (!fault_ok_o && !motor_enable_o))
    else $error("fault did not drop alarm and current"); // [R1]
  alarm_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    fault_ok_o == (fault_code_o == 3'b000))
    else $error("alarm output disagrees with latch"); // [R2]
  sticky_fault_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fault == mdf_pkg::MDF_F_NVDATA || fault == mdf_pkg::MDF_F_SYSTEM) |=> $stable(fault))
    else $error("unclearable fault released"); // [R12]
  clear_ok_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clr_edge && clearable && fault != mdf_pkg::MDF_F_NONE
      && next_fault == mdf_pkg::MDF_F_NONE) |=> fault_ok_o)
    else $error("clear did not restore alarm"); // [R10]
  held_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fault_clear_input_i && $past(fault_clear_input_i) && fault != mdf_pkg::MDF_F_NONE)
      |=> $stable(fault))
    else $error("held clear released fault"); // [R21]
  both_dir_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (two_pulse_mode_i && clockwise_cmd_input_i && counterclockwise_cmd_input_i) |=> !step_o)
    else $error("step with both directions active"); // [R13]
  coff_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    current_off_i |-> !motor_enable_o)
    else $error("motor excited under current off"); // [R15]
  steady_lamp_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fault == mdf_pkg::MDF_F_SYSTEM) [*2] |=> alarm_lamp_o)
    else $error("system fault lamp not steady"); // [R9]
  reset_clean_a: assert property (@(posedge core_clk_i)
    rst_i |=> (fault_code_o == 3'b000))
    else $error("fault latched after power-up"); // [R11]

  // Run lengths of the lamp, so pulse and pause widths can be bounded
  logic [31:0] lamp_run;
  logic [31:0] dark_run;

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !alarm_lamp_o) begin
      lamp_run <= 32'h0000_0000;
    end else begin
      lamp_run <= lamp_run + 32'h0000_0001;
    end
  end

  // Dark time before the first pulse is not a pause, so it restarts while idle
  always_ff @(posedge core_clk_i) begin
    if (rst_i || alarm_lamp_o || (fault == mdf_pkg::MDF_F_NONE)) begin
      dark_run <= 32'h0000_0000;
    end else begin
      dark_run <= dark_run + 32'h0000_0001;
    end
  end

  blink_width_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R18]
    (alarm_lamp_o && blink_count != mdf_pkg::BLINK_STEADY) |-> (lamp_run < BLINK_ON_CYC))
    else $error("blink pulse longer than its on time");
  gap_length_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R18]
    (!alarm_lamp_o && fault != mdf_pkg::MDF_F_NONE)
      |-> (dark_run < BLINK_OFF_CYC + BLINK_GAP_CYC))
    else $error("lamp dark longer than a group pause");
  lamp_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R2]
    fault_ok_o |=> !alarm_lamp_o)
    else $error("lamp lit without a fault");
  sensor_latch_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R8]
    (post_rst && cable_absent_i && !system_fail_i && !nv_corrupt_i)
      |=> (fault == mdf_pkg::MDF_F_SENSOR))
    else $error("missing cable at power-up not latched");
  sensor_once_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R8]
    (!post_rst && fault == mdf_pkg::MDF_F_NONE) |=> (fault != mdf_pkg::MDF_F_SENSOR))
    else $error("cable fault latched after power-up");
  ovld_latch_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R3]
    (fault == mdf_pkg::MDF_F_NONE && ovld_hit && !system_fail_i && !nv_corrupt_i
      && !post_rst) |=> (fault == mdf_pkg::MDF_F_OVLD))
    else $error("persistent overload not latched");
  step_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R1]
    !motor_enable_o |=> !step_o)
    else $error("step issued while current is cut");
  single_step_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R14]
    (motor_enable_o && !two_pulse_mode_i) |=> (step_o == $past(step_pulse_input_i)))
    else $error("single-pulse step not followed");
  dual_step_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R13]
    (motor_enable_o && two_pulse_mode_i)
      |=> (step_o == ($past(clockwise_cmd_input_i) != $past(counterclockwise_cmd_input_i))))
    else $error("two-pulse step not followed");
  dual_dir_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R16]
    two_pulse_mode_i |=> (table_ccw_o == $past(clockwise_cmd_input_i)))
    else $error("two-pulse table sense wrong");
  single_dir_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R14]
    !two_pulse_mode_i |=> (table_ccw_o == $past(rotation_sense_i)))
    else $error("single-pulse table sense wrong");
  tick_delay_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [R17]
    1'b1 |=> (angle_tick_output_o == $past(angle_tick_raw_i)))
    else $error("angle tick not passed on");

  fault_seen_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(!fault_ok_o));
  fault_cleared_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(fault_ok_o));
  system_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
    fault == mdf_pkg::MDF_F_SYSTEM);
  lamp_blink_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
    !fault_ok_o && $fell(alarm_lamp_o));
  sensor_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
    fault == mdf_pkg::MDF_F_SENSOR);

endmodule // mdf_fault_handler

`default_nettype wire

// *** dv/mdf_host_model.sv ***
// Host pulse-train controller model: clear pulses, current-off and step commands.
// Assumes the bench calls its tasks; every output changes on a falling clock edge.
`default_nettype none

module mdf_host_model #(
  parameter int unsigned WAIT_CYC = 5
) (
  // Clock, reset and device status
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic fault_ok_i,
  // Commands to the device
  output logic clear_o,
  output logic cur_off_o,
  output logic two_pulse_o,
  output logic cw_o,
  output logic ccw_o,
  output logic step_o,
  output logic sense_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int unsigned ok_cnt;

  initial begin
    {clear_o, cur_off_o, two_pulse_o, cw_o, ccw_o, step_o, sense_o} = 7'h00;
  end

  // Shortened settle time after the alarm output returns to its normal state
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !fault_ok_i) begin
      ok_cnt <= 0;
    end else if (ok_cnt < WAIT_CYC) begin
      ok_cnt <= ok_cnt + 1;
    end
  end

  task automatic set_clear(input logic v);
    @(negedge core_clk_i);
    clear_o = v;
  endtask

  task automatic clear_pulse();
    set_clear(1'b1);
    set_clear(1'b0);
  endtask

  task automatic set_cur_off(input logic v);
    @(negedge core_clk_i);
    cur_off_o = v;
  endtask

  // One command pulse; both directions at once only when the bench asks for it
  task automatic pulse(input logic two, input logic cw, input logic counterclockwise_cmd_input, input logic sns);
    @(negedge core_clk_i);
    two_pulse_o = two;
    sense_o = sns;
    while (fault_ok_i && ok_cnt < WAIT_CYC) @(negedge core_clk_i);
    cw_o = two & cw;
    ccw_o = two & counterclockwise_cmd_input;
    step_o = !two;
    @(negedge core_clk_i);
    cw_o = 1'b0;
    ccw_o = 1'b0;
    step_o = 1'b0;
  endtask
endmodule // mdf_host_model

`default_nettype wire

// *** dv/test_mdf_fault_handler.sv ***
// Self-checking bench for the fault handler, with shortened blink and overload counts.
// Assumes the host model drives the control inputs; detectors are driven here.
`default_nettype none

module test_mdf_fault_handler;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int ON = 4;
  localparam int OFF = 4;
  localparam int GAP = 12;
  localparam int OVL = 10;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic tick_raw = 1'b0;
  logic [6:0] det = 7'h00;
  wire logic clr, coff, two, cw, counterclockwise_cmd_input, stp, sense;
  wire logic ok, men, lamp, step, tccw, tick;
  wire logic [2:0] code;
  int errors = 0;
  int checks_done = 0;

  always #25 core_clk = ~core_clk;

  mdf_fault_handler #(.BLINK_ON_CYC(ON), .BLINK_OFF_CYC(OFF), .BLINK_GAP_CYC(GAP),
    .OVLD_CYC(OVL)) u_dut (
    .core_clk_i(core_clk), .rst_i(rst),
    .over_torque_i(det[0]), .over_voltage_i(det[1]), .follow_error_i(det[2]),
    .over_speed_i(det[3]), .nv_corrupt_i(det[4]), .cable_absent_i(det[5]),
    .system_fail_i(det[6]), .fault_clear_input_i(clr), .current_off_i(coff),
    .two_pulse_mode_i(two), .clockwise_cmd_input_i(cw), .counterclockwise_cmd_input_i(counterclockwise_cmd_input),
    .step_pulse_input_i(stp), .rotation_sense_i(sense), .angle_tick_raw_i(tick_raw),
    .fault_ok_o(ok), .motor_enable_o(men), .alarm_lamp_o(lamp), .fault_code_o(code),
    .step_o(step), .table_ccw_o(tccw), .angle_tick_output_o(tick));

  mdf_host_model #(.WAIT_CYC(5)) u_host (
    .core_clk_i(core_clk), .rst_i(rst), .fault_ok_i(ok), .clear_o(clr), .cur_off_o(coff),
    .two_pulse_o(two), .cw_o(cw), .ccw_o(counterclockwise_cmd_input), .step_o(stp), .sense_o(sense));

  task automatic results();
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic cable);
    @(negedge core_clk);
    rst = 1'b1;
    det[5] = cable;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    det[5] = 1'b0;
  endtask

  // Holds a detector for len cycles, then lets the latch settle
  task automatic raise(input int idx, input int len);
    @(negedge core_clk);
    det[idx] = 1'b1;
    repeat (len) @(negedge core_clk);
    det[idx] = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic latched(input logic [2:0] exp);
    chk(code, exp);
    chk(ok, 1'b0);
    chk(men, 1'b0);
  endtask

  // Counts pulses of one group and measures on, off and gap lengths
  task automatic blink(input int n);
    int hi, lo, k, w;
    w = 0;
    lo = 0;
    // Sync to a group start: a rise after a dark spell longer than one off time
    while (!(lamp === 1'b1 && lo > OFF) && w < 200) begin
      lo = (lamp === 1'b1) ? 0 : lo + 1;
      @(negedge core_clk);
      w++;
    end
    k = 0;
    lo = 0;
    while (lo <= OFF && k < 12) begin
      hi = 0;
      while (lamp === 1'b1 && hi < 100) begin
        @(negedge core_clk);
        hi++;
      end
      chk(8'(hi), 8'(ON));
      lo = 0;
      while (lamp !== 1'b1 && lo < 100) begin
        @(negedge core_clk);
        lo++;
      end
      k++;
    end
    chk(8'(k), 8'(n));
    chk(8'(lo == GAP || lo == GAP + OFF), 8'h01);
  endtask

  task automatic steps(input logic tw, input logic c, input logic cc, input logic s,
    input logic e_step, input logic e_ccw);
    u_host.pulse(tw, c, cc, s);
    chk(step, e_step);
    if (e_step) chk(tccw, e_ccw);
  endtask

  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    results();
  end

  initial begin
    logic [2:0] codes [3];
    logic [3:0] cnts [3];
    codes = '{mdf_pkg::MDF_F_OVOLT, mdf_pkg::MDF_F_SPDERR, mdf_pkg::MDF_F_OVSPD};
    cnts = '{mdf_pkg::BLINK_OVOLT, mdf_pkg::BLINK_SPDERR, mdf_pkg::BLINK_OVSPD};
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk({ok, men, lamp, 2'b00, code}, 8'hc0);
    for (int i = 0; i < 3; i++) begin
      raise(i + 1, 1);
      latched(codes[i]);
      blink(int'(cnts[i]));
      steps(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      u_host.clear_pulse();
      chk({ok, men, 3'b000, code}, 8'hc0);
    end
    raise(0, OVL - 1);
    repeat (3) @(negedge core_clk);
    chk(code, mdf_pkg::MDF_F_NONE);
    raise(0, OVL + 2);
    latched(mdf_pkg::MDF_F_OVLD);
    raise(1, 1);
    latched(mdf_pkg::MDF_F_OVLD);
    blink(int'(mdf_pkg::BLINK_OVLD));
    u_host.set_clear(1'b1);
    @(negedge core_clk);
    chk(ok, 1'b1);
    raise(2, 1);
    repeat (4) @(negedge core_clk);
    latched(mdf_pkg::MDF_F_SPDERR);
    u_host.set_clear(1'b0);
    u_host.clear_pulse();
    chk(ok, 1'b1);
    raise(4, 1);
    latched(mdf_pkg::MDF_F_NVDATA);
    blink(int'(mdf_pkg::BLINK_NVDATA));
    u_host.clear_pulse();
    latched(mdf_pkg::MDF_F_NVDATA);
    do_reset(1'b0);
    chk({ok, 4'h0, code}, 8'h80);
    raise(6, 1);
    latched(mdf_pkg::MDF_F_SYSTEM);
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < 3 * (ON + OFF) + GAP; i++) begin
      @(negedge core_clk);
      chk(lamp, 1'b1);
    end
    u_host.clear_pulse();
    latched(mdf_pkg::MDF_F_SYSTEM);
    do_reset(1'b1);
    latched(mdf_pkg::MDF_F_SENSOR);
    blink(int'(mdf_pkg::BLINK_SENSOR));
    do_reset(1'b0);
    steps(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    steps(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    steps(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    steps(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    steps(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    u_host.set_cur_off(1'b1);
    #1 chk(men, 1'b0);
    steps(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    u_host.set_cur_off(1'b0);
    #1 chk(men, 1'b1);
    @(negedge core_clk);
    tick_raw = 1'b1;
    @(negedge core_clk);
    tick_raw = 1'b0;
    chk(tick, 1'b1);
    @(negedge core_clk);
    chk(tick, 1'b0);
    results();
  end
endmodule // test_mdf_fault_handler

`default_nettype wire
